// *** shared/drive_common_regs.vh ***
// Address map, field layout and codes of the common parameter area
`ifndef DRIVE_COMMON_REGS_VH
`define DRIVE_COMMON_REGS_VH

`define ADDR_MODEL_CODE      16'h0000
`define ADDR_POWER_RATING    16'h0001
`define ADDR_VOLTAGE_CLASS   16'h0002
`define ADDR_FW_VERSION      16'h0003
`define ADDR_PROTECT_KEY     16'h0004
`define ADDR_SPEED_SETPOINT  16'h0005
`define ADDR_COMMAND_WORD    16'h0006
`define ADDR_RAMP_UP         16'h0007
`define ADDR_RAMP_DOWN       16'h0008
`define ADDR_LOAD_CURRENT    16'h0009
`define ADDR_ACTUAL_FREQ     16'h000A
`define ADDR_APPLIED_VOLT    16'h000B
`define ADDR_BUS_VOLT        16'h000C
`define ADDR_DELIV_POWER     16'h000D
`define ADDR_STATE_FLAGS     16'h000E
`define ADDR_FAULT_FLAGS     16'h000F
`define ADDR_INPUT_LEVELS    16'h0010

`define KEY_LOCKED           1'b0
`define KEY_UNLOCKED         1'b1
`define KEY_RESET            1'b0

`define CMD_STOP_BIT         0
`define CMD_FWD_BIT          1
`define CMD_REV_BIT          2
`define CMD_FRESET_BIT       3
`define CMD_ESTOP_BIT        4
`define CMD_PULSE_W          5
`define CMD_OPSRC_LSB        6
`define CMD_OPSRC_MSB        7
`define CMD_FSRC_LSB         8
`define CMD_FSRC_MSB         12

`define FSRC_FIRST_VOLTAGE   5'h0C
`define FSRC_SECOND_VOLTAGE  5'h0D
`define FSRC_CURRENT         5'h0E
`define FSRC_V0_PLUS_I       5'h0F
`define FSRC_V1_PLUS_I       5'h10
`define FSRC_JOG             5'h11
`define FSRC_PID             5'h12
`define FSRC_COMM            5'h13

`define STATE_FLAGS_MASK     16'h3DFF
`define FAULT_FLAGS_MASK     16'h7FFF
`define INPUT_LEVELS_MASK    16'h000F

`define ERR_NONE             16'h0000
`define ERR_WRITE_MODE       16'h574D
`define ERR_INVALID_ADDR     16'h4941

`define SETPOINT_RESET       16'h0000
`define RAMP_RESET           16'h0000

`endif

// *** verif/drive_map_checker.sv ***
// Assertion checker bound to the common parameter register bank
`timescale 1ns/1ns
module drive_map_checker #(
    parameter [15:0] START_FREQ = 16'h0032,
    parameter [15:0] MAX_FREQ = 16'h1770
) (
    // Clock, reset and request
    input wire core_clk,
    input wire nrst,
    input wire req_valid,
    input wire req_write,
    input wire [15:0] req_addr,
    input wire [15:0] req_wdata,
    // Answer and core side
    input wire rsp_valid,
    input wire rsp_ok,
    input wire [15:0] rsp_err_code,
    input wire [15:0] rsp_rdata,
    input wire [15:0] drive_state_in,
    input wire [15:0] fault_cause_in,
    input wire [1:0] op_source_in,
    input wire [4:0] freq_source_in,
    input wire params_unlocked,
    input wire [15:0] speed_setpoint,
    input wire forward_request
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    wire rd = req_valid && !req_write;
    wire wr = req_valid && req_write;
    wire wm = !rsp_ok && rsp_err_code == 16'h574D;
    sequence unlock_s;
        wr && req_addr == 16'h0004 && req_wdata[0] ##1 rsp_ok;
    endsequence
    sequence setpoint_s;
        wr && req_addr == 16'h0005 ##1 rsp_ok;
    endsequence
    answer_next_a: assert property (req_valid |=> rsp_valid) else $error("answer missing");
    answer_only_a: assert property (!req_valid |=> !rsp_valid) else $error("answer without request");
    bad_addr_a: assert property (req_valid && req_addr > 16'h0010 |=> !rsp_ok && rsp_err_code == 16'h4941)
        else $error("bad address not refused");
    ro_write_a: assert property (wr && (req_addr < 16'h0004 || (req_addr > 16'h0008 && req_addr < 16'h0011))
        |=> wm) else $error("read-only write not refused");
    // Idle cycle before means the key cannot have moved ahead of params_unlocked
    locked_write_a: assert property (wr && req_addr > 16'h0004 && req_addr < 16'h0009 && !params_unlocked
        && !$past(req_valid) |=> wm) else $error("locked write not refused");
    state_read_a: assert property (rd && req_addr == 16'h000E |=> rsp_rdata == ($past(drive_state_in) & 16'h3DFF))
        else $error("state flags wrong");
    fault_read_a: assert property (rd && req_addr == 16'h000F |=> rsp_rdata == ($past(fault_cause_in) & 16'h7FFF))
        else $error("fault flags wrong");
    source_read_a: assert property (rd && req_addr == 16'h0006 |=> rsp_rdata[15:5] ==
        {3'b000, $past(freq_source_in), $past(op_source_in), 1'b0}) else $error("source field wrong");
    unlock_follows_a: assert property (unlock_s |=> params_unlocked) else $error("unlock not seen");
    setpoint_clamp_a: assert property (setpoint_s |=> speed_setpoint >= START_FREQ && speed_setpoint <= MAX_FREQ)
        else $error("setpoint out of range");
    forward_cause_a: assert property (forward_request |-> rsp_ok && $past(wr && req_addr == 16'h0006
        && req_wdata[1])) else $error("forward pulse without command");
endmodule
bind drive_common_parameter_map drive_map_checker #(.START_FREQ(START_FREQ), .MAX_FREQ(MAX_FREQ)) u_drive_map_checker (
    .core_clk, .nrst, .req_valid, .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_ok, .rsp_err_code,
    .rsp_rdata, .drive_state_in, .fault_cause_in, .op_source_in, .freq_source_in, .params_unlocked,
    .speed_setpoint, .forward_request);

// *** verif/serial_master_model.sv ***
// Master model issuing word requests to the parameter area
`timescale 1ns/1ns
module serial_master_model (
    // Clock
    input wire core_clk,
    // Request side
    output reg req_valid = 1'b0,
    output reg req_write = 1'b0,
    output reg [15:0] req_addr = 16'h0000,
    output reg [15:0] req_wdata = 16'h0000,
    // Answer side
    input wire rsp_valid,
    input wire rsp_ok,
    input wire [15:0] rsp_err_code,
    input wire [15:0] rsp_rdata
);
    reg [33:0] ans = 34'h000000000;
    // Called at a falling edge; more keeps the strobe up for back-to-back use
    task xfer(input w, input [15:0] a, input [15:0] d, input more);
        begin
            req_valid <= 1'b1;
            req_write <= w;
            req_addr <= a;
            req_wdata <= d;
            @(negedge core_clk);
            ans = {rsp_valid, rsp_ok, rsp_err_code, rsp_rdata};
            if (!more) begin
                req_valid <= 1'b0;
                // Inverse on released lines so stale values never look valid
                req_addr <= ~a;
                req_wdata <= ~d;
                @(negedge core_clk);
            end
        end
    endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the common parameter register bank
`timescale 1ns/1ns
module tb;
    localparam [15:0] MODEL = 16'h00C3; // Arbitrary identity value
    localparam [15:0] FWV = 16'h0042; // Arbitrary identity value
    localparam [15:0] SF = 16'h0032;
    localparam [15:0] MF = 16'h1770;
    localparam [15:0] WM = 16'h574D;
    localparam [15:0] IA = 16'h4941;
    reg core_clk = 1'b0;
    reg nrst = 1'b0;
    reg [15:0] st = 16'h0000;
    reg [15:0] ft = 16'h0000;
    reg [79:0] mv = 80'h0;
    reg [1:0] ops = 2'b00;
    reg [4:0] fs = 5'h00;
    reg [3:0] term = 4'h0;
    reg [31:0] seed = 32'h00007DDF;
    reg [15:0] v;
    reg [15:0] sp = 16'h0000;
    reg [15:0] ru = 16'h0000;
    reg [15:0] rdn = 16'h0000;
    reg [4:0] cmd = 5'h00;
    reg [4:0] seen = 5'h00;
    reg clr_seen = 1'b0;
    integer errors = 0;
    integer num_checks = 0;
    integer i;
    integer b;
    wire req_valid;
    wire req_write;
    wire [15:0] req_addr;
    wire [15:0] req_wdata;
    wire rsp_valid;
    wire rsp_ok;
    wire [15:0] rsp_err_code;
    wire [15:0] rsp_rdata;
    wire unl;
    wire [15:0] sp_out;
    wire [15:0] up_out;
    wire [15:0] dn_out;
    wire [4:0] pul;
    always #4 core_clk = ~core_clk;
    // Only this process writes seen; the stimulus asks for a clear
    always @(posedge core_clk) seen <= (clr_seen ? 5'h00 : seen) | pul;
    drive_common_parameter_map #(.MODEL_CODE(MODEL), .FW_VERSION(FWV), .START_FREQ(SF), .MAX_FREQ(MF))
        u_drive_common_parameter_map (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok), .rsp_err_code(rsp_err_code), .rsp_rdata(rsp_rdata), .drive_state_in(st),
        .fault_cause_in(ft), .op_source_in(ops), .freq_source_in(fs), .load_current_in(mv[15:0]),
        .actual_frequency_in(mv[31:16]), .applied_voltage_in(mv[47:32]), .bus_voltage_in(mv[63:48]),
        .delivered_power_in(mv[79:64]), .input_terminal_1(term[0]), .input_terminal_2(term[1]),
        .input_terminal_3(term[2]), .input_terminal_4(term[3]), .params_unlocked(unl),
        .speed_setpoint(sp_out), .ramp_up_time(up_out), .ramp_down_time(dn_out), .stop_request(pul[0]),
        .forward_request(pul[1]), .reverse_request(pul[2]), .fault_reset_request(pul[3]),
        .emergency_stop_request(pul[4]));
    serial_master_model u_serial_master_model (.core_clk(core_clk), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok), .rsp_err_code(rsp_err_code), .rsp_rdata(rsp_rdata));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    function [15:0] clampf(input [15:0] x);
        clampf = x < SF ? SF : (x > MF ? MF : x);
    endfunction
    task check(input string name, input [33:0] got, input [33:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("mismatch %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task acc(input w, input [15:0] a, input [15:0] d, input more, input ok, input [15:0] err, input [15:0] rd);
        begin
            u_serial_master_model.xfer(w, a, d, more);
            check("answer", u_serial_master_model.ans, {1'b1, ok, err, rd});
        end
    endtask
    task rd_ok(input [15:0] a, input [15:0] exp, input more);
        acc(1'b0, a, 16'h0000, more, 1'b1, 16'h0000, exp);
    endtask
    task bad(input w, input [15:0] a, input [15:0] err);
        begin
            seed = xs(seed);
            acc(w, a, seed[15:0], 1'b0, 1'b0, err, 16'h0000);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", num_checks, errors);
            if (errors == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        #60000;
        errors = errors + 1;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        rd_ok(16'h0000, MODEL, 1);
        rd_ok(16'h0003, FWV, 1);
        rd_ok(16'h0004, 16'h0000, 1);
        rd_ok(16'h0005, 16'h0000, 0);
        $display("test 1 done");
        bad(1, 16'h0005, WM);
        bad(1, 16'h0000, WM);
        bad(1, 16'h0010, WM);
        bad(1, 16'h0011, IA);
        bad(0, 16'hFFFF, IA);
        rd_ok(16'h0005, 16'h0000, 0);
        $display("test 2 done");
        acc(1, 16'h0004, 16'hFFFF, 0, 1, 16'h0000, 16'h0000);
        rd_ok(16'h0004, 16'h0001, 0);
        check("params_unlocked", {33'h0, unl}, 34'h1);
        for (i = 0; i < 12; i = i + 1) begin
            seed = xs(seed);
            v = i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : i == 2 ? SF - 1 : i == 3 ? MF + 1 : {3'b000, seed[12:0]};
            acc(1, 16'h0005, v, 1, 1, 16'h0000, sp);
            sp = clampf(v);
            acc(1, 16'h0007, seed[31:16], 1, 1, 16'h0000, ru);
            ru = seed[31:16];
            acc(1, 16'h0008, ~seed[15:0], 0, 1, 16'h0000, rdn);
            rdn = ~seed[15:0];
            rd_ok(16'h0005, sp, 1);
            rd_ok(16'h0007, ru, 0);
            check("ramp outputs", {2'b00, sp_out, up_out}, {2'b00, sp, ru});
            check("ramp_down_time", {18'h0, dn_out}, {18'h0, rdn});
        end
        $display("test 3 done");
        for (b = 0; b < 5; b = b + 1) begin
            seed = xs(seed);
            clr_seen = 1'b1;
            @(negedge core_clk);
            clr_seen = 1'b0;
            acc(1, 16'h0006, {seed[15:5], 5'h00}, 1, 1, 16'h0000, {3'b000, fs, ops, 1'b0, cmd});
            acc(1, 16'h0006, {seed[15:5], 5'h01 << b}, 0, 1, 16'h0000, {11'h000, 5'h00});
            check("pulse", {29'h0, seen}, {29'h0, 5'h01 << b});
            cmd = 5'h01 << b;
            clr_seen = 1'b1;
            @(negedge core_clk);
            clr_seen = 1'b0;
            acc(1, 16'h0006, {seed[15:5], cmd}, 0, 1, 16'h0000, {11'h000, cmd});
            check("pulse", {29'h0, seen}, 34'h0);
            rd_ok(16'h0006, {11'h000, cmd}, 0);
        end
        for (i = 12; i < 32; i = i + 1) begin
            seed = xs(seed);
            fs = i[4:0];
            ops = seed[1:0];
            rd_ok(16'h0006, {3'b000, fs, ops, 1'b0, cmd}, i < 31);
        end
        acc(1, 16'h0004, 16'h0000, 0, 1, 16'h0000, 16'h0001);
        bad(1, 16'h0007, WM);
        $display("test 4 done");
        for (i = 0; i < 16; i = i + 1) begin
            seed = xs(seed);
            {st, ft} = i == 0 ? 32'hFFFFFFFF : seed;
            seed = xs(seed);
            mv = {seed, seed, seed[15:0] ^ 16'hA5C3};
            term = i == 0 ? 4'hF : seed[3:0];
            // Terminals pass a two-flop synchroniser before they can be read
            repeat (3) @(negedge core_clk);
            rd_ok(16'h000E, st & 16'h3DFF, 1);
            rd_ok(16'h000F, ft & 16'h7FFF, 1);
            for (b = 0; b < 5; b = b + 1)
                rd_ok(b[15:0] + 16'h0009, mv[16*b +: 16], 1);
            rd_ok(16'h0010, {12'h000, term}, 0);
        end
        $display("test 5 done");
        tally_and_finish;
    end
endmodule

// *** verilog/drive_common_parameter_map.v ***
// Common parameter area register bank of a motor drive
`timescale 1ns/1ns
`include "drive_common_regs.vh"

// Functional notes
// - Protect key word is read/write; 0 locked, 1 unlocked; comes up locked.
// - Command bits 0,1,2 request stop, forward, reverse on a 0-to-1 change only.
// - Command word holds read-only frequency source field, codes 12..19 used, 20..31 reserved.
// - Source codes: current input 14, V0+I 15, V1+I 16, jog 17.
// - Ramp-up time word is read/write, one count is 0.1 second.
// - Speed setpoint is read/write in 0.01 Hz, kept between start and maximum frequency; only written values are clamped, reset loads 0.
// - State flags read-only: bit0 stopped, bit1 forward, bit2 reverse, bit3 fault trip.
// - State flags bit4 accelerating, bit5 decelerating, bit6 target speed reached.
// - State flags bit7 DC braking, bit8 stopping, bit9 unused.
// - State flags bit10 brake open, bit11 forward run command active.
// - State flags bit12 reverse run command active, bit13 remote run/stop state.
// - Fault flags read-only: bit2 external trip A, bit3 emergency stop, bit4 collision trip.
// - Fault flags bit5 ground fault, bit6 drive overheat, bit7 motor overheat.
// - Fault flags bit8 overload, bit9 hardware diagnostic, bit10 external trip B.
// - Fault flags bit11 parameter store error, bit12 cooling fan error.
// - Fault flags bit13 output phase open, bit14 drive overload trip.
// - Input levels word read-only, terminals 1..4 in bits 0..3.
// - Write to an unwritable word is refused with the write-mode error code.
// - Access outside the map is refused with the invalid-address error code.
module drive_common_parameter_map #(
    // Arbitrary value
    parameter [15:0] MODEL_CODE = 16'h005E,
    parameter [15:0] POWER_RATING = 16'h0000,
    parameter [15:0] VOLTAGE_CLASS = 16'h0000,
    // Arbitrary value
    parameter [15:0] FW_VERSION = 16'h0021,
    parameter [15:0] START_FREQ = 16'h0032,
    parameter [15:0] MAX_FREQ = 16'h1770
) (
    // Clock and reset
    input wire core_clk,
    input wire nrst,
    // Word access port
    input wire req_valid,
    input wire req_write,
    input wire [15:0] req_addr,
    input wire [15:0] req_wdata,
    output reg rsp_valid,
    output reg rsp_ok,
    output reg [15:0] rsp_err_code,
    output reg [15:0] rsp_rdata,
    // Drive core status, same clock
    input wire [15:0] drive_state_in,
    input wire [15:0] fault_cause_in,
    input wire [1:0] op_source_in,
    input wire [4:0] freq_source_in,
    input wire [15:0] load_current_in,
    input wire [15:0] actual_frequency_in,
    input wire [15:0] applied_voltage_in,
    input wire [15:0] bus_voltage_in,
    input wire [15:0] delivered_power_in,
    // Input terminal pins, asynchronous
    input wire input_terminal_1,
    input wire input_terminal_2,
    input wire input_terminal_3,
    input wire input_terminal_4,
    // Controls to the drive core
    output reg params_unlocked,
    output reg [15:0] speed_setpoint,
    output reg [15:0] ramp_up_time,
    output reg [15:0] ramp_down_time,
    output reg stop_request,
    output reg forward_request,
    output reg reverse_request,
    output reg fault_reset_request,
    output reg emergency_stop_request
);

    reg [3:0] term_meta_r;
    reg [3:0] term_sync_r;
    reg write_protect_key_r;
    reg [15:0] speed_setpoint_r;
    reg [15:0] ramp_up_time_r;
    reg [15:0] ramp_down_time_r;
    reg [`CMD_PULSE_W-1:0] cmd_bits_r;
    reg [`CMD_PULSE_W-1:0] cmd_bits_nxt;
    reg [`CMD_PULSE_W-1:0] cmd_pulse_nxt;
    reg [15:0] read_word;
    reg addr_valid;
    reg addr_writable;
    reg [15:0] err_nxt;
    reg do_write;

    // Map membership is needed only for the error path; the read mux falls to its own default
    function in_map;
        input [15:0] a;
        begin
            in_map = (a <= `ADDR_INPUT_LEVELS);
        end
    endfunction

    function is_rw;
        input [15:0] a;
        begin
            is_rw = (a == `ADDR_PROTECT_KEY) || (a == `ADDR_SPEED_SETPOINT) ||
                    (a == `ADDR_COMMAND_WORD) || (a == `ADDR_RAMP_UP) ||
                    (a == `ADDR_RAMP_DOWN);
        end
    endfunction

    // Out-of-range setpoints are clamped rather than refused
    function [15:0] clamp_freq;
        input [15:0] v;
        begin
            if (v < START_FREQ) begin
                clamp_freq = START_FREQ;
            end else if (v > MAX_FREQ) begin
                clamp_freq = MAX_FREQ;
            end else begin
                clamp_freq = v;
            end
        end
    endfunction

    wire [3:0] term_pins;

    assign term_pins = {input_terminal_4, input_terminal_3, input_terminal_2, input_terminal_1};

    // Terminals are pins, so two flops before use
    genvar t;
    generate
        for (t = 0; t < 4; t = t + 1) begin : g_term_sync
            always @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    term_meta_r[t] <= 1'b0;
                    term_sync_r[t] <= 1'b0;
                end else begin
                    term_meta_r[t] <= term_pins[t];
                    term_sync_r[t] <= term_meta_r[t];
                end
            end
        end
    endgenerate

    always @* begin
        read_word = 16'h0000;
        case (req_addr)
            `ADDR_MODEL_CODE: begin
                read_word = MODEL_CODE;
            end
            `ADDR_POWER_RATING: begin
                read_word = POWER_RATING;
            end
            `ADDR_VOLTAGE_CLASS: begin
                read_word = VOLTAGE_CLASS;
            end
            `ADDR_FW_VERSION: begin
                read_word = FW_VERSION;
            end
            `ADDR_PROTECT_KEY: begin
                read_word = {15'h0000, write_protect_key_r};
            end
            `ADDR_SPEED_SETPOINT: begin
                read_word = speed_setpoint_r;
            end
            `ADDR_COMMAND_WORD: begin
                read_word[`CMD_PULSE_W-1:0] = cmd_bits_r;
                read_word[`CMD_OPSRC_MSB:`CMD_OPSRC_LSB] = op_source_in;
                read_word[`CMD_FSRC_MSB:`CMD_FSRC_LSB] = freq_source_in;
            end
            `ADDR_RAMP_UP: begin
                read_word = ramp_up_time_r;
            end
            `ADDR_RAMP_DOWN: begin
                read_word = ramp_down_time_r;
            end
            `ADDR_LOAD_CURRENT: begin
                read_word = load_current_in;
            end
            `ADDR_ACTUAL_FREQ: begin
                read_word = actual_frequency_in;
            end
            `ADDR_APPLIED_VOLT: begin
                read_word = applied_voltage_in;
            end
            `ADDR_BUS_VOLT: begin
                read_word = bus_voltage_in;
            end
            `ADDR_DELIV_POWER: begin
                read_word = delivered_power_in;
            end
            `ADDR_STATE_FLAGS: begin
                // Bit 9 and bits 14..15 forced low
                read_word = drive_state_in & `STATE_FLAGS_MASK;
            end
            `ADDR_FAULT_FLAGS: begin
                read_word = fault_cause_in & `FAULT_FLAGS_MASK;
            end
            `ADDR_INPUT_LEVELS: begin
                read_word = {12'h000, term_sync_r} & `INPUT_LEVELS_MASK;
            end
            default: begin
                read_word = 16'h0000;
            end
        endcase
    end

    always @* begin
        addr_valid = in_map(req_addr);
        addr_writable = is_rw(req_addr);
        err_nxt = `ERR_NONE;
        if (!addr_valid) begin
            err_nxt = `ERR_INVALID_ADDR;
        end else if (req_write && !addr_writable) begin
            err_nxt = `ERR_WRITE_MODE;
        end else if (req_write && (req_addr != `ADDR_PROTECT_KEY) &&
                     (write_protect_key_r == `KEY_LOCKED)) begin
            err_nxt = `ERR_WRITE_MODE;
        end
        do_write = req_valid && req_write && (err_nxt == `ERR_NONE);
    end

    // Only the low command bits are stored; source fields are never written
    always @* begin
        cmd_bits_nxt = cmd_bits_r;
        if (do_write && (req_addr == `ADDR_COMMAND_WORD)) begin
            cmd_bits_nxt = req_wdata[`CMD_PULSE_W-1:0];
        end
        cmd_pulse_nxt = cmd_bits_nxt & ~cmd_bits_r;
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            write_protect_key_r <= `KEY_RESET;
            speed_setpoint_r <= `SETPOINT_RESET;
            ramp_up_time_r <= `RAMP_RESET;
            ramp_down_time_r <= `RAMP_RESET;
            cmd_bits_r <= {`CMD_PULSE_W{1'b0}};
        end else begin
            cmd_bits_r <= cmd_bits_nxt;
            if (do_write) begin
                case (req_addr)
                    `ADDR_PROTECT_KEY: begin
                        write_protect_key_r <= req_wdata[0];
                    end
                    `ADDR_SPEED_SETPOINT: begin
                        speed_setpoint_r <= clamp_freq(req_wdata);
                    end
                    `ADDR_RAMP_UP: begin
                        ramp_up_time_r <= req_wdata;
                    end
                    `ADDR_RAMP_DOWN: begin
                        ramp_down_time_r <= req_wdata;
                    end
                    default: begin
                        write_protect_key_r <= write_protect_key_r;
                    end
                endcase
            end
        end
    end

    // Response and control outputs all from flops
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_valid <= 1'b0;
            rsp_ok <= 1'b0;
            rsp_err_code <= `ERR_NONE;
            rsp_rdata <= 16'h0000;
            params_unlocked <= 1'b0;
            speed_setpoint <= `SETPOINT_RESET;
            ramp_up_time <= `RAMP_RESET;
            ramp_down_time <= `RAMP_RESET;
            stop_request <= 1'b0;
            forward_request <= 1'b0;
            reverse_request <= 1'b0;
            fault_reset_request <= 1'b0;
            emergency_stop_request <= 1'b0;
        end else begin
            rsp_valid <= req_valid;
            rsp_ok <= req_valid && (err_nxt == `ERR_NONE);
            rsp_err_code <= req_valid ? err_nxt : `ERR_NONE;
            // A write answers with the value held before it
            rsp_rdata <= (req_valid && (err_nxt == `ERR_NONE)) ? read_word : 16'h0000;
            params_unlocked <= (write_protect_key_r == `KEY_UNLOCKED);
            speed_setpoint <= speed_setpoint_r;
            ramp_up_time <= ramp_up_time_r;
            ramp_down_time <= ramp_down_time_r;
            stop_request <= cmd_pulse_nxt[`CMD_STOP_BIT];
            forward_request <= cmd_pulse_nxt[`CMD_FWD_BIT];
            reverse_request <= cmd_pulse_nxt[`CMD_REV_BIT];
            fault_reset_request <= cmd_pulse_nxt[`CMD_FRESET_BIT];
            emergency_stop_request <= cmd_pulse_nxt[`CMD_ESTOP_BIT];
        end
    end

endmodule
